/* File: shared/dmc_pkg.sv */
// How it works
// - only read holding, write single and write multiple functions are served.
// - the logic command word is written with write single to register 8192.
// - command writes act only while run command origin selects value 5.
// - the logic command register reads back with read holding registers.
// - bit 0 high requests stop, bit 1 high requests start.
// - bit 2 high requests jog, bit 3 high clears active faults.
// - bits 5..4: 01 forward, 10 reverse, 00 and 11 keep direction.
// - newer firmware: bits 6,7 drive opto outputs when their function is 20.
// - bits 9..8: 01 accel rate one, 10 rate two, else no change.
// - bits 11..10: 01 decel rate one, 10 rate two, else no change.
// - bits 14..12 pick frequency source; 000 leaves it unchanged.
// - newer firmware: bit 15 drives the changeover relay when so configured.
// - the speed reference is written with write single to register 8193.
// - the network reference is used while frequency origin selects 5 or bits 14..12 select source 011.
// - the reference register reads back its last written value.
// - the reference is unsigned tenths of a hertz, stored as written.
package dmc_pkg;

  localparam int unsigned CLK_HZ         = 125_000_000;
  localparam int unsigned BAUD_DEFAULT   = 19_200;
  localparam int unsigned CHAR_BITS      = 11;
  localparam int unsigned GAP_HALF_CHARS = 7;

  localparam logic [15:0] REG_LOGIC_CMD   = 16'h2000;
  localparam logic [15:0] REG_SPEED_REF   = 16'h2001;
  localparam logic [15:0] LOGIC_CMD_RESET = 16'h0000;
  localparam logic [15:0] SPEED_REF_RESET = 16'h0000;

  localparam logic [7:0] FC_READ_HOLD  = 8'h03;
  localparam logic [7:0] FC_WRITE_ONE  = 8'h06;
  localparam logic [7:0] FC_WRITE_MANY = 8'h10;
  localparam logic [7:0] EXC_FLAG      = 8'h80;
  localparam logic [7:0] EXC_ILL_FUNC  = 8'h01;
  localparam logic [7:0] EXC_ILL_ADDR  = 8'h02;
  localparam logic [7:0] EXC_ILL_VALUE = 8'h03;
  localparam logic [7:0] BROADCAST_ADDR = 8'h00;

  localparam logic [15:0] MAX_READ_QTY  = 16'h007D;
  localparam logic [15:0] MAX_WRITE_QTY = 16'h007B;
  localparam int unsigned MIN_FRAME     = 4;
  localparam int unsigned LEN_FIXED_REQ = 8;
  localparam int unsigned LEN_MANY_HDR  = 9;
  localparam int unsigned LEN_READ_HDR  = 3;
  localparam int unsigned LEN_ECHO_RSP  = 6;
  localparam int unsigned LEN_EXC_RSP   = 3;

  localparam logic [3:0] SEL_NETWORK_PORT   = 4'h5;
  localparam logic [4:0] OUT_FUNC_NETWORK   = 5'h14;
  localparam logic [4:0] RELAY_FUNC_NETWORK = 5'h14;
  localparam logic [7:0] FW_NEW_MAJOR       = 8'h04;

  localparam logic [1:0] SEL2_ONE  = 2'b01;
  localparam logic [1:0] SEL2_TWO  = 2'b10;
  localparam logic [2:0] FSRC_NONE = 3'b000;
  localparam logic [2:0] FSRC_CONFIGURED = 3'b001;
  localparam logic [2:0] FSRC_NETWORK    = 3'b011;

  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;
  localparam logic [3:0]  UART_LAST_BIT = 4'h9;

  typedef struct packed {
    logic       relay;
    logic [2:0] freq_src;
    logic [1:0] decel;
    logic [1:0] accel;
    logic       opto2;
    logic       opto1;
    logic [1:0] dir;
    logic       clear_faults;
    logic       jog;
    logic       start;
    logic       stop;
  } dmc_logic_cmd_t;

  function automatic logic [15:0] dmc_crc_byte(input logic [15:0] crc,
                                               input logic [7:0]  data);
    logic [15:0] c;
    c = crc ^ {8'h00, data};
    for (int i = 0; i < 8; i++)
    begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

endpackage

/* File: verilog/dmc_uart_rx.sv */
`timescale 1ns/1ps
module dmc_uart_rx
  import dmc_pkg::*;
#(
  parameter int unsigned BIT_CYCLES = CLK_HZ / BAUD_DEFAULT
)
(
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  input  wire logic       rx_i,
  output logic [7:0]      data_o,
  output logic            valid_o
);

  localparam int unsigned CW = $clog2(BIT_CYCLES);

  logic          busy_r;
  logic [CW-1:0] cnt_r;
  logic [3:0]    bit_r;
  logic [7:0]    shift_r;

  // first sample lands mid start bit, then one per bit period
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      busy_r  <= 1'b0;
      cnt_r   <= '0;
      bit_r   <= 4'h0;
      shift_r <= 8'h00;
      data_o  <= 8'h00;
      valid_o <= 1'b0;
    end
    else
    begin
      valid_o <= 1'b0;
      if (!busy_r)
      begin
        if (!rx_i)
        begin
          busy_r <= 1'b1;
          cnt_r  <= CW'(BIT_CYCLES / 2);
          bit_r  <= 4'h0;
        end
      end
      else if (cnt_r != '0)
      begin
        cnt_r <= cnt_r - 1'b1;
      end
      else
      begin
        cnt_r <= CW'(BIT_CYCLES - 1);
        bit_r <= bit_r + 4'h1;
        if (bit_r == 4'h0)
        begin
          // a start bit gone high by mid bit was a glitch
          if (rx_i)
            busy_r <= 1'b0;
        end
        else if (bit_r == UART_LAST_BIT)
        begin
          busy_r <= 1'b0;
          if (rx_i)
          begin
            data_o  <= shift_r;
            valid_o <= 1'b1;
          end
        end
        else
        begin
          shift_r <= {rx_i, shift_r[7:1]};
        end
      end
    end
  end

endmodule

/* File: verilog/dmc_uart_tx.sv */
`timescale 1ns/1ps
module dmc_uart_tx
  import dmc_pkg::*;
#(
  parameter int unsigned BIT_CYCLES = CLK_HZ / BAUD_DEFAULT
)
(
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  input  wire logic [7:0] data_i,
  input  wire logic       valid_i,
  input  wire logic       hold_i,
  output logic            ready_o,
  output logic            busy_o,
  output logic            tx_o,
  output logic            oe_n_o
);

  localparam int unsigned CW = $clog2(BIT_CYCLES);

  logic          busy_r;
  logic [CW-1:0] cnt_r;
  logic [3:0]    bit_r;
  logic [8:0]    shift_r;

  assign ready_o = !busy_r;
  assign busy_o  = busy_r;

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      busy_r  <= 1'b0;
      cnt_r   <= '0;
      bit_r   <= 4'h0;
      shift_r <= 9'h1FF;
      tx_o    <= 1'b1;
      oe_n_o  <= 1'b1;
    end
    else if (!busy_r)
    begin
      if (valid_i)
      begin
        busy_r  <= 1'b1;
        cnt_r   <= CW'(BIT_CYCLES - 1);
        bit_r   <= 4'h0;
        shift_r <= {1'b1, data_i};
        tx_o    <= 1'b0;
        oe_n_o  <= 1'b0;
      end
    end
    else if (cnt_r != '0)
    begin
      cnt_r <= cnt_r - 1'b1;
    end
    else if (bit_r == UART_LAST_BIT)
    begin
      busy_r <= 1'b0;
      // keep the driver on between bytes of one reply
      oe_n_o <= !hold_i;
    end
    else
    begin
      cnt_r   <= CW'(BIT_CYCLES - 1);
      bit_r   <= bit_r + 4'h1;
      tx_o    <= shift_r[0];
      shift_r <= {1'b1, shift_r[8:1]};
    end
  end

endmodule

/* File: verilog/dmc_cmd_regs.sv */
`timescale 1ns/1ps
module dmc_cmd_regs
  import dmc_pkg::*;
#(
  parameter int unsigned BIT_CYCLES = CLK_HZ / BAUD_DEFAULT,
  parameter int unsigned RX_DEPTH   = 16
)
(
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  input  wire logic       rx_i,
  input  wire logic [7:0] node_addr_i,
  input  wire logic [3:0] run_command_origin_select_i,
  input  wire logic [3:0] frequency_origin_select_i,
  input  wire logic [4:0] opto_out1_function_select_i,
  input  wire logic [4:0] opto_out2_function_select_i,
  input  wire logic [4:0] relay_function_select_i,
  input  wire logic [7:0] firmware_revision_i,
  output logic            tx_o,
  output logic            tx_oe_n_o,
  output logic            stop_req_o,
  output logic            start_req_o,
  output logic            jog_req_o,
  output logic            clear_faults_o,
  output logic            dir_reverse_o,
  output logic            accel_rate_two_o,
  output logic            decel_rate_two_o,
  output logic [2:0]      freq_source_o,
  output logic            opto_out1_o,
  output logic            opto_out2_o,
  output logic            relay_out_o,
  output logic [15:0]     speed_ref_o,
  output logic            net_ref_in_use_o
);

  // 3.5 character times of silence close a frame
  localparam int unsigned GAP_CYCLES =
    (BIT_CYCLES * CHAR_BITS * GAP_HALF_CHARS + 1) / 2;
  localparam int unsigned GW = $clog2(GAP_CYCLES + 1);
  localparam int unsigned IW = $clog2(RX_DEPTH + 1);

  typedef enum logic [1:0] {
    ST_RECV,
    ST_DECODE,
    ST_SEND,
    ST_DRAIN
  } dmc_state_t;

  typedef enum logic [1:0] {
    RSP_ECHO,
    RSP_READ,
    RSP_EXC
  } dmc_rsp_t;

  function automatic logic in_map(input logic [15:0] start,
                                  input logic [15:0] qty);
    return (start >= REG_LOGIC_CMD) &&
           ({1'b0, start} + {1'b0, qty} <= {1'b0, REG_SPEED_REF} + 17'h1);
  endfunction

  dmc_state_t     state_r;
  logic [7:0]     rx_byte;
  logic           rx_valid;
  logic [7:0]     rxbuf [RX_DEPTH];
  logic [IW-1:0]  rx_cnt_r;
  logic           rx_ovf_r;
  logic [15:0]    rx_crc_r;
  logic [GW-1:0]  gap_r;

  dmc_logic_cmd_t cmd_r;
  logic [15:0]    ref_r;
  logic           opto1_cmd_r;
  logic           opto2_cmd_r;
  logic           relay_cmd_r;

  dmc_rsp_t       rsp_kind_r;
  logic [7:0]     rsp_code_r;
  logic [IW-1:0]  tx_len_r;
  logic [IW-1:0]  tx_idx_r;
  logic [15:0]    tx_crc_r;
  logic [7:0]     tx_byte;
  logic           tx_valid;
  logic           tx_ready;
  logic           tx_busy;

  logic [7:0]     fc;
  logic [15:0]    start;
  logic [15:0]    qty;
  logic           bcast;
  logic           dec_ok;
  dmc_rsp_t       dec_kind;
  logic [7:0]     dec_code;
  logic [IW-1:0]  dec_len;
  logic           wr_cmd;
  logic           wr_ref;
  dmc_logic_cmd_t wr_cmd_val;
  logic [15:0]    wr_ref_val;
  logic           accept;
  logic           run_net;
  logic           fw_new;

  dmc_uart_rx #(
    .BIT_CYCLES (BIT_CYCLES)
  ) u_rx (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .rx_i      (rx_i),
    .data_o    (rx_byte),
    .valid_o   (rx_valid)
  );

  dmc_uart_tx #(
    .BIT_CYCLES (BIT_CYCLES)
  ) u_tx (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .data_i    (tx_byte),
    .valid_i   (tx_valid),
    .hold_i    (tx_valid),
    .ready_o   (tx_ready),
    .busy_o    (tx_busy),
    .tx_o      (tx_o),
    .oe_n_o    (tx_oe_n_o)
  );

  // frame collection; own echo and bytes during a reply are ignored
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      rx_cnt_r <= '0;
      rx_ovf_r <= 1'b0;
      rx_crc_r <= CRC_INIT;
      gap_r    <= '0;
    end
    else if (state_r != ST_RECV)
    begin
      rx_cnt_r <= '0;
      rx_ovf_r <= 1'b0;
      rx_crc_r <= CRC_INIT;
      gap_r    <= '0;
    end
    else if (rx_valid)
    begin
      gap_r    <= '0;
      rx_crc_r <= dmc_crc_byte(rx_crc_r, rx_byte);
      if (rx_cnt_r == IW'(RX_DEPTH))
        rx_ovf_r <= 1'b1;
      else
        rx_cnt_r <= rx_cnt_r + 1'b1;
    end
    else if (gap_r != GW'(GAP_CYCLES))
    begin
      gap_r <= gap_r + 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (state_r == ST_RECV && rx_valid && rx_cnt_r != IW'(RX_DEPTH))
      rxbuf[rx_cnt_r[IW-2:0]] <= rx_byte;
  end

  assign fc    = rxbuf[1];
  assign start = {rxbuf[2], rxbuf[3]};
  assign qty   = {rxbuf[4], rxbuf[5]};
  assign bcast = (rxbuf[0] == BROADCAST_ADDR);

  // request check; a bad crc, foreign address or odd length drops silently
  always_comb
  begin
    dec_ok     = !rx_ovf_r && rx_cnt_r >= IW'(MIN_FRAME) &&
                 rx_crc_r == 16'h0000 &&
                 (bcast || rxbuf[0] == node_addr_i);
    dec_kind   = RSP_ECHO;
    dec_code   = 8'h00;
    dec_len    = IW'(LEN_ECHO_RSP);
    wr_cmd     = 1'b0;
    wr_ref     = 1'b0;
    wr_cmd_val = dmc_logic_cmd_t'({rxbuf[4], rxbuf[5]});
    wr_ref_val = {rxbuf[4], rxbuf[5]};
    case (fc)
      FC_READ_HOLD:
      begin
        dec_ok  = dec_ok && rx_cnt_r == IW'(LEN_FIXED_REQ);
        dec_kind = RSP_READ;
        dec_len = IW'(LEN_READ_HDR) + IW'({qty[1:0], 1'b0});
        if (qty == 16'h0000 || qty > MAX_READ_QTY)
          dec_code = EXC_ILL_VALUE;
        else if (!in_map(start, qty))
          dec_code = EXC_ILL_ADDR;
      end
      FC_WRITE_ONE:
      begin
        dec_ok = dec_ok && rx_cnt_r == IW'(LEN_FIXED_REQ);
        if (!in_map(start, 16'h0001))
          dec_code = EXC_ILL_ADDR;
        else
        begin
          wr_cmd = (start == REG_LOGIC_CMD);
          wr_ref = (start == REG_SPEED_REF);
        end
      end
      FC_WRITE_MANY:
      begin
        if (qty == 16'h0000 || qty > MAX_WRITE_QTY ||
            {8'h00, rxbuf[6]} != {qty[14:0], 1'b0})
          dec_code = EXC_ILL_VALUE;
        else
        begin
          dec_ok = dec_ok && ({8'h00, rxbuf[6]} + 16'(LEN_MANY_HDR) ==
                              16'(rx_cnt_r));
          if (!in_map(start, qty))
            dec_code = EXC_ILL_ADDR;
          else
          begin
            wr_cmd     = (start == REG_LOGIC_CMD);
            wr_ref     = (start == REG_SPEED_REF) || qty[1];
            wr_cmd_val = dmc_logic_cmd_t'({rxbuf[7], rxbuf[8]});
            wr_ref_val = (start == REG_SPEED_REF) ?
                         {rxbuf[7], rxbuf[8]} : {rxbuf[9], rxbuf[10]};
          end
        end
      end
      default:
      begin
        dec_code = EXC_ILL_FUNC;
      end
    endcase
    if (dec_code != 8'h00)
    begin
      dec_kind = RSP_EXC;
      dec_len  = IW'(LEN_EXC_RSP);
      wr_cmd   = 1'b0;
      wr_ref   = 1'b0;
    end
  end

  assign accept  = (state_r == ST_DECODE) && dec_ok;
  assign run_net = (run_command_origin_select_i == SEL_NETWORK_PORT);
  assign fw_new  = (firmware_revision_i >= FW_NEW_MAJOR);

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      state_r    <= ST_RECV;
      rsp_kind_r <= RSP_ECHO;
      rsp_code_r <= 8'h00;
      tx_len_r   <= '0;
      tx_idx_r   <= '0;
      tx_crc_r   <= CRC_INIT;
    end
    else
    begin
      unique case (state_r)
        ST_RECV:
        begin
          if (gap_r == GW'(GAP_CYCLES) && rx_cnt_r != '0)
            state_r <= ST_DECODE;
        end
        ST_DECODE:
        begin
          // broadcasts write but never answer
          if (dec_ok && !bcast)
          begin
            state_r    <= ST_SEND;
            rsp_kind_r <= dec_kind;
            rsp_code_r <= dec_code;
            tx_len_r   <= dec_len;
            tx_idx_r   <= '0;
            tx_crc_r   <= CRC_INIT;
          end
          else
            state_r <= ST_RECV;
        end
        ST_SEND:
        begin
          if (tx_ready)
          begin
            tx_idx_r <= tx_idx_r + 1'b1;
            if (tx_idx_r < tx_len_r)
              tx_crc_r <= dmc_crc_byte(tx_crc_r, tx_byte);
            if (tx_idx_r == tx_len_r + 1'b1)
              state_r <= ST_DRAIN;
          end
        end
        ST_DRAIN:
        begin
          if (!tx_busy)
            state_r <= ST_RECV;
        end
      endcase
    end
  end

  assign tx_valid = (state_r == ST_SEND);

  // reply bytes come straight from the request buffer and registers
  always_comb
  begin
    logic [IW-1:0] rel;
    logic [15:0]   word;
    rel  = tx_idx_r - IW'(LEN_READ_HDR);
    // start is one of the two mapped words and qty at most two
    word = (start == REG_LOGIC_CMD && !rel[1]) ?
           16'(cmd_r) : ref_r;
    if (tx_idx_r == tx_len_r)
      tx_byte = tx_crc_r[7:0];
    else if (tx_idx_r == tx_len_r + 1'b1)
      tx_byte = tx_crc_r[15:8];
    else if (tx_idx_r == '0)
      tx_byte = rxbuf[0];
    else if (rsp_kind_r == RSP_EXC)
      tx_byte = (tx_idx_r == IW'(1)) ? (fc | EXC_FLAG) : rsp_code_r;
    else if (rsp_kind_r == RSP_READ && tx_idx_r == IW'(2))
      tx_byte = {qty[6:0], 1'b0};
    else if (rsp_kind_r == RSP_READ && tx_idx_r > IW'(2))
      tx_byte = rel[0] ? word[7:0] : word[15:8];
    else
      tx_byte = rxbuf[tx_idx_r[IW-2:0]];
  end

  // stored as written so the word always reads back
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      cmd_r <= dmc_logic_cmd_t'(LOGIC_CMD_RESET);
    else if (accept && wr_cmd)
      cmd_r <= wr_cmd_val;
  end

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      ref_r <= SPEED_REF_RESET;
    else if (accept && wr_ref)
      ref_r <= wr_ref_val;
  end

  assign speed_ref_o = ref_r;

  // one-cycle requests, only when the network owns run control
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      stop_req_o     <= 1'b0;
      start_req_o    <= 1'b0;
      jog_req_o      <= 1'b0;
      clear_faults_o <= 1'b0;
    end
    else
    begin
      stop_req_o     <= accept && wr_cmd && run_net &&
                        wr_cmd_val.stop;
      start_req_o    <= accept && wr_cmd && run_net &&
                        wr_cmd_val.start;
      jog_req_o      <= accept && wr_cmd && run_net &&
                        wr_cmd_val.jog;
      clear_faults_o <= accept && wr_cmd && run_net &&
                        wr_cmd_val.clear_faults;
    end
  end

  // direction, rate and source selections change only on a code that names a choice; opto and relay bits follow each write while run origin is 5
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      dir_reverse_o    <= 1'b0;
      accel_rate_two_o <= 1'b0;
      decel_rate_two_o <= 1'b0;
      freq_source_o    <= FSRC_CONFIGURED;
      opto1_cmd_r      <= 1'b0;
      opto2_cmd_r      <= 1'b0;
      relay_cmd_r      <= 1'b0;
    end
    else if (accept && wr_cmd && run_net)
    begin
      if (wr_cmd_val.dir == SEL2_ONE)
        dir_reverse_o <= 1'b0;
      else if (wr_cmd_val.dir == SEL2_TWO)
        dir_reverse_o <= 1'b1;
      if (wr_cmd_val.accel == SEL2_ONE)
        accel_rate_two_o <= 1'b0;
      else if (wr_cmd_val.accel == SEL2_TWO)
        accel_rate_two_o <= 1'b1;
      if (wr_cmd_val.decel == SEL2_ONE)
        decel_rate_two_o <= 1'b0;
      else if (wr_cmd_val.decel == SEL2_TWO)
        decel_rate_two_o <= 1'b1;
      if (wr_cmd_val.freq_src != FSRC_NONE)
        freq_source_o <= wr_cmd_val.freq_src;
      opto1_cmd_r <= wr_cmd_val.opto1;
      opto2_cmd_r <= wr_cmd_val.opto2;
      relay_cmd_r <= wr_cmd_val.relay;
    end
  end

  // older firmware never drives the auxiliary outputs from the word
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      opto_out1_o      <= 1'b0;
      opto_out2_o      <= 1'b0;
      relay_out_o      <= 1'b0;
      net_ref_in_use_o <= 1'b0;
    end
    else
    begin
      opto_out1_o <= fw_new && opto1_cmd_r &&
        opto_out1_function_select_i == OUT_FUNC_NETWORK;
      opto_out2_o <= fw_new && opto2_cmd_r &&
        opto_out2_function_select_i == OUT_FUNC_NETWORK;
      relay_out_o <= fw_new && relay_cmd_r &&
        relay_function_select_i == RELAY_FUNC_NETWORK;
      net_ref_in_use_o <=
        frequency_origin_select_i == SEL_NETWORK_PORT ||
        freq_source_o == FSRC_NETWORK;
    end
  end

endmodule

/* File: verification/dmc_cmd_regs_chk.sv */
`timescale 1ns/1ps
module dmc_cmd_regs_chk
  import dmc_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  input  wire logic [3:0] run_command_origin_select_i,
  input  wire logic [3:0] frequency_origin_select_i,
  input  wire logic [4:0] opto_out1_function_select_i,
  input  wire logic [4:0] relay_function_select_i,
  input  wire logic [7:0] firmware_revision_i,
  input  wire logic       stop_req_o,
  input  wire logic       start_req_o,
  input  wire logic       jog_req_o,
  input  wire logic       clear_faults_o,
  input  wire logic       dir_reverse_o,
  input  wire logic [2:0] freq_source_o,
  input  wire logic       opto_out1_o,
  input  wire logic       relay_out_o,
  input  wire logic       net_ref_in_use_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  wire logic new_fw = firmware_revision_i >= FW_NEW_MAJOR;
  wire logic any_pulse = stop_req_o | start_req_o | jog_req_o | clear_faults_o;

  property p_stop_pulse;
    stop_req_o |=> !stop_req_o;
  endproperty
  a_stop_pulse: assert property (p_stop_pulse)
    else $error("stop pulse longer than one cycle");
  property p_start_pulse;
    start_req_o |=> !start_req_o;
  endproperty
  a_start_pulse: assert property (p_start_pulse)
    else $error("start pulse longer than one cycle");
  property p_jog_pulse;
    jog_req_o |=> !jog_req_o;
  endproperty
  a_jog_pulse: assert property (p_jog_pulse)
    else $error("jog pulse longer than one cycle");
  property p_clr_pulse;
    clear_faults_o |=> !clear_faults_o;
  endproperty
  a_clr_pulse: assert property (p_clr_pulse)
    else $error("clear pulse longer than one cycle");
  property p_pulse_gate;
    any_pulse |-> $past(run_command_origin_select_i) == SEL_NETWORK_PORT;
  endproperty
  a_pulse_gate: assert property (p_pulse_gate)
    else $error("command pulse while run origin is not network");
  property p_dir_gate;
    $changed(dir_reverse_o)
      |-> $past(run_command_origin_select_i) == SEL_NETWORK_PORT;
  endproperty
  a_dir_gate: assert property (p_dir_gate)
    else $error("direction moved while run origin is not network");
  property p_opto_gate;
    !(new_fw && opto_out1_function_select_i == OUT_FUNC_NETWORK)
      |=> !opto_out1_o;
  endproperty
  a_opto_gate: assert property (p_opto_gate)
    else $error("opto output high without network function");
  property p_relay_gate;
    !(new_fw && relay_function_select_i == RELAY_FUNC_NETWORK)
      |=> !relay_out_o;
  endproperty
  a_relay_gate: assert property (p_relay_gate)
    else $error("relay high without network function");
  property p_net_ref;
    $past(reset_n_i) |-> net_ref_in_use_o == $past(freq_source_o ==
      FSRC_NETWORK || frequency_origin_select_i == SEL_NETWORK_PORT);
  endproperty
  a_net_ref: assert property (p_net_ref)
    else $error("network reference use flag wrong");
endmodule

bind dmc_cmd_regs dmc_cmd_regs_chk u_chk (.*);

/* File: verification/dmc_mst_model.sv */
`timescale 1ns/1ps
module dmc_mst_model
#(
  parameter int BIT = 8
)
(
  input  wire logic clk_i,
  input  wire logic tx_i,
  output logic      rx_o
);
  // biased bus idles high between frames
  initial rx_o = 1'b1;
  function automatic logic [15:0] crc(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (q[i])
    begin
      c ^= {8'h00, q[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    end
    return c;
  endfunction
  // register numbers go out zero-based, as given
  task automatic send(input logic [7:0] q[$]);
    logic [15:0] c;
    logic [9:0]  sh;
    c = crc(q);
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    foreach (q[i])
    begin
      sh = {1'b1, q[i], 1'b0};
      for (int b = 0; b < 10; b++)
      begin
        @(posedge clk_i);
        rx_o <= sh[b];
        repeat (BIT - 1) @(posedge clk_i);
      end
    end
  endtask
  // samples mid-bit; a missing start bit ends the wait early
  task automatic recv(input int n, output logic [7:0] q[$], output bit ok);
    int t;
    q = {};
    ok = 1'b0;
    repeat (n)
    begin
      t = 0;
      while (tx_i !== 1'b0 && t < 3000)
      begin
        @(posedge clk_i);
        t++;
      end
      if (t >= 3000) return;
      repeat (BIT / 2) @(posedge clk_i);
      q.push_back(8'h00);
      for (int b = 0; b < 8; b++)
      begin
        repeat (BIT) @(posedge clk_i);
        q[$][b] = tx_i;
      end
      repeat (BIT) @(posedge clk_i);
    end
    ok = 1'b1;
  endtask
endmodule

/* File: verification/dmc_cmd_regs_tb.sv */
`timescale 1ns/1ps
module dmc_cmd_regs_tb
  import dmc_pkg::*;
;
  localparam int         BITC = 8;
  localparam logic [7:0] N    = 8'h11;
  logic       clk_i = 1'b0, reset_n_i = 1'b0, rx;
  logic [3:0] run_s = 4'h5, frq_s = 4'h0;
  logic [4:0] ofn = 5'h14;
  logic [7:0] fw = 8'h04;
  logic       tx, oe_n, stp, sta, jog, clr, dir, acc, dec, o1, o2, rl, nr;
  logic [2:0] fs;
  logic [15:0] spd;
  int         pc[4], snap[4];
  int         miscompares = 0, num_checks = 0, cyc = 0;
  wire logic [3:0] pls = {clr, jog, sta, stp};
  logic [15:0] cw[13] = '{16'h0002, 16'h0001, 16'h0004, 16'h0008, 16'h0020,
    16'h0030, 16'h0010, 16'h0200, 16'h0300, 16'h0100, 16'h0800, 16'h0C00,
    16'h0400};
  logic [6:0] ev[13] = '{7'h10, 7'h08, 7'h20, 7'h40, 7'h04, 7'h04, 7'h00,
    7'h02, 7'h02, 7'h00, 7'h01, 7'h01, 7'h00};

  always #4 clk_i = ~clk_i;
  dmc_cmd_regs #(.BIT_CYCLES(BITC)) DUT (.clk_i(clk_i),
    .reset_n_i(reset_n_i), .rx_i(rx), .node_addr_i(N),
    .run_command_origin_select_i(run_s), .frequency_origin_select_i(frq_s),
    .opto_out1_function_select_i(ofn), .opto_out2_function_select_i(ofn),
    .relay_function_select_i(ofn), .firmware_revision_i(fw), .tx_o(tx),
    .tx_oe_n_o(oe_n), .stop_req_o(stp), .start_req_o(sta), .jog_req_o(jog),
    .clear_faults_o(clr), .dir_reverse_o(dir), .accel_rate_two_o(acc),
    .decel_rate_two_o(dec), .freq_source_o(fs), .opto_out1_o(o1),
    .opto_out2_o(o2), .relay_out_o(rl), .speed_ref_o(spd),
    .net_ref_in_use_o(nr));
  dmc_mst_model #(.BIT(BITC)) mst (.clk_i(clk_i), .tx_i(tx), .rx_o(rx));

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge clk_i)
  begin
    for (int k = 0; k < 4; k++) pc[k] += pls[k];
    cyc++;
    if (cyc == 90000)
    begin
      miscompares++;
      wrap_up();
    end
  end
  task automatic chk(input string nm, input logic [15:0] e, g);
    num_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // pulse bits are stop, start, jog, clear; levels end with net ref use
  task automatic outs(input logic [3:0] p, input logic [9:0] l);
    logic [3:0] g;
    for (int k = 0; k < 4; k++) g[k] = pc[k] != snap[k];
    chk("pulses", {12'h0, p}, {12'h0, g});
    chk("levels", {6'h0, l}, {6'h0, dir, acc, dec, fs, o1, o2, rl, nr});
  endtask
  task automatic xfer(input logic [7:0] rq[$], ex[$]);
    logic [7:0]  rs[$];
    logic [15:0] c;
    bit          ok;
    snap = pc;
    mst.send(rq);
    c = mst.crc(ex);
    ex.push_back(c[7:0]);
    ex.push_back(c[15:8]);
    mst.recv(ex.size(), rs, ok);
    chk("reply seen", 16'h1, {15'h0, ok});
    chk("driver on", 16'h0, {15'h0, oe_n});
    foreach (ex[i]) chk("reply byte", {8'h00, ex[i]}, {8'h00, rs[i]});
    // next request only after a full idle gap
    repeat (320) @(posedge clk_i);
    chk("driver off", 16'h1, {15'h0, oe_n});
  endtask
  task automatic wr(input logic [15:0] a, v);
    logic [7:0] q[$];
    q = {N, FC_WRITE_ONE, a[15:8], a[7:0], v[15:8], v[7:0]};
    xfer(q, q);
  endtask
  task automatic rd(input logic [15:0] a, e);
    xfer({N, FC_READ_HOLD, a[15:8], a[7:0], 8'h00, 8'h01},
         {N, FC_READ_HOLD, 8'h02, e[15:8], e[7:0]});
  endtask

  initial
  begin
    repeat (5) @(posedge clk_i);
    reset_n_i <= 1'b1;
    @(posedge clk_i);
    outs(4'h0, {3'b000, 3'b001, 3'b000, 1'b0});
    chk("speed ref", 16'h0000, spd);
    xfer({N, 8'h03, 8'h20, 8'h00, 8'h00, 8'h02},
         {N, 8'h03, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00});
    for (int i = 0; i < 13; i++)
    begin
      wr(REG_LOGIC_CMD, cw[i]);
      outs(ev[i][6:3], {ev[i][2:0], 3'b001, 4'h0});
    end
    for (int f = 1; f < 8; f++)
    begin
      wr(REG_LOGIC_CMD, {1'b0, f[2:0], 12'h000});
      outs(4'h0, {3'b000, f[2:0], 3'b000, f == 3});
    end
    wr(REG_LOGIC_CMD, 16'h0000);
    outs(4'h0, {3'b000, 3'd7, 4'h0});
    @(posedge clk_i) fw <= 8'h03;
    wr(REG_LOGIC_CMD, 16'h80C0);
    outs(4'h0, {3'b000, 3'd7, 4'h0});
    @(posedge clk_i) fw <= 8'h04;
    wr(REG_LOGIC_CMD, 16'h80C0);
    outs(4'h0, {3'b000, 3'd7, 3'b111, 1'b0});
    @(posedge clk_i) ofn <= 5'h00;
    repeat (2) @(posedge clk_i);
    outs(4'h0, {3'b000, 3'd7, 3'b000, 1'b0});
    @(posedge clk_i) ofn <= 5'h14;
    @(posedge clk_i) run_s <= 4'h0;
    wr(REG_LOGIC_CMD, 16'h0022);
    outs(4'h0, {3'b000, 3'd7, 3'b111, 1'b0});
    rd(REG_LOGIC_CMD, 16'h0022);
    @(posedge clk_i) run_s <= 4'h5;
    @(posedge clk_i) frq_s <= 4'h5;
    wr(REG_SPEED_REF, 16'd543);
    chk("speed ref", 16'd543, spd);
    rd(REG_SPEED_REF, 16'd543);
    xfer({N, 8'h10, 8'h20, 8'h00, 8'h00, 8'h02, 8'h04, 8'h00, 8'h04,
          8'h12, 8'h34}, {N, 8'h10, 8'h20, 8'h00, 8'h00, 8'h02});
    outs(4'b0100, {3'b000, 3'd7, 3'b000, 1'b1});
    chk("speed ref", 16'h1234, spd);
    for (logic [7:0] fc = 8'h04; fc < 8'h06; fc++)
    begin
      xfer({N, fc, 8'h20, 8'h00, 8'h00, 8'h01},
           {N, fc | EXC_FLAG, EXC_ILL_FUNC});
      outs(4'h0, {3'b000, 3'd7, 3'b000, 1'b1});
      chk("speed ref", 16'h1234, spd);
    end
    wrap_up();
  end
endmodule
